//--- pwlk_params.svh
`ifndef PWLK_PARAMS_SVH
`define PWLK_PARAMS_SVH

// number of peripheral groups, one lock bit each
`define PWLK_NUM_GROUPS 8
`define PWLK_GROUP_W 3

// firmware access carrier widths
`define PWLK_ADDR_W 12
`define PWLK_DATA_W 32

// key register data width and the two key values (values arbitrary)
`define PWLK_KEY_W 8
`define PWLK_KEY_FIRST 8'ha5
`define PWLK_KEY_SECOND 8'hf1

// lock mask value after reset: every group released
`define PWLK_LOCK_RESET 8'h00

// key status encodings as seen on the status port
`define PWLK_STATUS_W 2
`define PWLK_STATUS_LOCKED 2'h0
`define PWLK_STATUS_FIRST 2'h1
`define PWLK_STATUS_UNLOCKED 2'h3

`endif

//--- pwlk_pkg.sv
`include "pwlk_params.svh"

package pwlk_pkg;

   // key sequencer states, gray coded along locked -> first -> unlocked
   typedef enum logic [`PWLK_STATUS_W-1:0] {
      PWLK_KEY_LOCKED = `PWLK_STATUS_LOCKED,
      PWLK_KEY_FIRST = `PWLK_STATUS_FIRST,
      PWLK_KEY_UNLOCKED = `PWLK_STATUS_UNLOCKED
   } pwlk_key_state_e;

   // one firmware access towards a peripheral register
   typedef struct packed {
      logic valid;
      logic write;
      logic [`PWLK_GROUP_W-1:0] group;
      logic [`PWLK_ADDR_W-1:0] addr;
      logic [`PWLK_DATA_W-1:0] wdata;
   } pwlk_access_s;

endpackage : pwlk_pkg

//--- pwlk_key_seq.sv
`timescale 1ns/10ps
`include "pwlk_params.svh"

module pwlk_key_seq
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic key_wr_in,
   input wire logic [`PWLK_KEY_W-1:0] key_data_in,
   output pwlk_pkg::pwlk_key_state_e state_out,
   output logic unlocked_out
);

   pwlk_pkg::pwlk_key_state_e state;
   pwlk_pkg::pwlk_key_state_e next_state;

   // next state: only key writes move the sequence
   always_comb
   begin
      next_state = state;
      if (key_wr_in)
      begin
         case (state)
            pwlk_pkg::PWLK_KEY_LOCKED:
            begin
               if (key_data_in == `PWLK_KEY_FIRST)
                  next_state = pwlk_pkg::PWLK_KEY_FIRST;
               else
                  next_state = pwlk_pkg::PWLK_KEY_LOCKED;
            end
            pwlk_pkg::PWLK_KEY_FIRST:
            begin
               if (key_data_in == `PWLK_KEY_SECOND)
                  next_state = pwlk_pkg::PWLK_KEY_UNLOCKED;
               else
                  next_state = pwlk_pkg::PWLK_KEY_LOCKED;
            end
            pwlk_pkg::PWLK_KEY_UNLOCKED:
               next_state = pwlk_pkg::PWLK_KEY_LOCKED; // any value re-arms
            default:
               next_state = pwlk_pkg::PWLK_KEY_LOCKED;
         endcase
      end
   end

   // state register, protected after reset
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         state <= pwlk_pkg::PWLK_KEY_LOCKED;
      else
         state <= next_state;
   end

   assign state_out = state;
   assign unlocked_out = (state == pwlk_pkg::PWLK_KEY_UNLOCKED);

endmodule : pwlk_key_seq

//--- pwlk_top.sv
`timescale 1ns/10ps
`include "pwlk_params.svh"

// Summary of operation
// - each lock mask bit write-protects one whole peripheral group together
// - lock mask changes only after the full ordered key sequence is written
// - any key write after unlocking re-protects the lock mask until sequence repeats
// - key status output shows whether the lock mask is locked, has seen the first key, or is unlocked
// - writes to a locked group are dropped, peripheral contents stay unchanged
// - reads of any peripheral always pass through, locked or not

module pwlk_top
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // key register writes and the key status
   input wire logic key_wr_in,
   input wire logic [`PWLK_KEY_W-1:0] key_data_in,
   output logic [`PWLK_STATUS_W-1:0] key_status_out,
   // lock mask writes and the current mask
   input wire logic lock_wr_in,
   input wire logic [`PWLK_NUM_GROUPS-1:0] lock_data_in,
   output logic [`PWLK_NUM_GROUPS-1:0] peripheral_group_lock_mask_out,
   output logic lock_wr_refused_out,
   // firmware access in, filtered access out towards the peripherals
   input wire pwlk_pkg::pwlk_access_s cpu_acc_in,
   output pwlk_pkg::pwlk_access_s periph_acc_out,
   output logic [`PWLK_NUM_GROUPS-1:0] group_wr_en_out,
   // report of the most recent dropped write
   output logic wr_blocked_out,
   output logic [`PWLK_GROUP_W-1:0] blocked_group_out
);

   // true when an access addresses the given group
   function automatic logic group_hit
   (
      input logic [`PWLK_GROUP_W-1:0] grp,
      input int unsigned idx
   );
      group_hit = (grp == idx[`PWLK_GROUP_W-1:0]);
   endfunction : group_hit

   // true for a valid firmware write; the lane enables and the drop path both need it
   function automatic logic wr_request
   (
      input pwlk_pkg::pwlk_access_s acc
   );
      wr_request = acc.valid && acc.write;
   endfunction : wr_request

   // key sequencer view
   pwlk_pkg::pwlk_key_state_e key_state;
   logic unlocked;

   // lock mask and its refusal report
   logic [`PWLK_NUM_GROUPS-1:0] lock_mask;
   logic [`PWLK_NUM_GROUPS-1:0] next_lock_mask;
   logic lock_wr_refused;
   logic next_lock_wr_refused;

   // registered access path and drop report
   genvar g;
   pwlk_pkg::pwlk_access_s periph_acc;
   pwlk_pkg::pwlk_access_s next_periph_acc;
   logic [`PWLK_NUM_GROUPS-1:0] group_wr_en;
   logic [`PWLK_NUM_GROUPS-1:0] next_group_wr_en;
   logic wr_blocked;
   logic next_wr_blocked;
   logic [`PWLK_GROUP_W-1:0] blocked_group;
   logic [`PWLK_GROUP_W-1:0] next_blocked_group;
   logic target_locked;

   // key sequence tracking lives in its own small machine
   pwlk_key_seq u_key_seq
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .key_wr_in(key_wr_in),
      .key_data_in(key_data_in),
      .state_out(key_state),
      .unlocked_out(unlocked)
   );

   // lock mask lanes: each bit takes the written value only while the key
   // sequence is complete; the registered unlock state gates the write, so a key
   // write and a lock write in the same cycle still see the old unlock state
   generate
      for (g = 0; g < `PWLK_NUM_GROUPS; g = g + 1)
      begin : gen_lock
         always_comb
         begin
            next_lock_mask[g] = lock_mask[g];
            if (lock_wr_in && unlocked)
               next_lock_mask[g] = lock_data_in[g];
         end
      end
   endgenerate

   // lock mask register, every group released after reset
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         lock_mask <= `PWLK_LOCK_RESET;
      else
         lock_mask <= next_lock_mask;
   end

   // refusal report: a lock write outside the unlocked state changes nothing
   always_comb
   begin
      next_lock_wr_refused = 1'b0;
      if (lock_wr_in && !unlocked)
         next_lock_wr_refused = 1'b1; // locked mask ignores the write
   end

   // refusal pulse lasts one cycle; firmware sees no other sign of it
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         lock_wr_refused <= 1'b0;
      else
         lock_wr_refused <= next_lock_wr_refused;
   end

   // one bit covers every register of its group, whatever the address
   assign target_locked = lock_mask[cpu_acc_in.group];

   // forwarded access: locked writes vanish, reads always go through
   always_comb
   begin
      next_periph_acc = cpu_acc_in; // reads pass unchanged, never qualified by the mask
      next_wr_blocked = 1'b0;
      next_blocked_group = blocked_group;
      if (wr_request(cpu_acc_in) && target_locked)
      begin
         next_periph_acc.valid = 1'b0; // peripheral never sees the write
         next_periph_acc.wdata = '0; // blocked data is not leaked onto the peripheral side
         next_wr_blocked = 1'b1;
         next_blocked_group = cpu_acc_in.group; // holds until the next drop
      end
   end

   // per-group write enables, one lane per lock bit
   generate
      for (g = 0; g < `PWLK_NUM_GROUPS; g = g + 1)
      begin : gen_group
         always_comb
         begin
            next_group_wr_en[g] = wr_request(cpu_acc_in) &&
                                  group_hit(cpu_acc_in.group, g) && !lock_mask[g];
         end
      end
   endgenerate

   // one cycle of latency keeps every data output registered
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         periph_acc <= '0;
      else
         periph_acc <= next_periph_acc;
   end

   // lane enables share the access copy's timing, so the peripheral sees both together
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         group_wr_en <= '0;
      else
         group_wr_en <= next_group_wr_en;
   end

   // drop report: the pulse and the group that caused it
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_blocked <= 1'b0;
         blocked_group <= '0;
      end
      else
      begin
         wr_blocked <= next_wr_blocked;
         blocked_group <= next_blocked_group;
      end
   end

   // key and lock view; only the unlocked status code permits mask changes
   assign key_status_out = key_state;
   assign peripheral_group_lock_mask_out = lock_mask;
   assign lock_wr_refused_out = lock_wr_refused;

   // filtered access towards the peripherals
   assign periph_acc_out = periph_acc;
   assign group_wr_en_out = group_wr_en;

   // drop report
   assign wr_blocked_out = wr_blocked;
   assign blocked_group_out = blocked_group;

endmodule : pwlk_top

//--- pwlk_periph_model.sv
`timescale 1ns/10ps
// peripheral words behind the lock unit, one per group
module pwlk_periph_model
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire pwlk_pkg::pwlk_access_s acc_in,
   input wire logic [7:0] wr_en_in,
   output logic [31:0] rd_data_out
);
   logic [31:0] mem [8];
   // only enabled writes land, so a dropped write leaves the word intact
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         mem <= '{default: 32'h0};
      else if (acc_in.valid && acc_in.write && wr_en_in[acc_in.group])
         mem[acc_in.group] <= acc_in.wdata;
   end
   assign rd_data_out = mem[acc_in.group]; // reads always answer
endmodule : pwlk_periph_model

//--- pwlk_top_asserts.sv
`timescale 1ns/10ps
`include "pwlk_params.svh"
module pwlk_top_asserts
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic key_wr_in,
   input wire logic [7:0] key_data_in,
   input wire logic [1:0] key_status_out,
   input wire logic lock_wr_in,
   input wire logic [7:0] lock_data_in,
   input wire logic [7:0] peripheral_group_lock_mask_out,
   input wire logic lock_wr_refused_out,
   input wire pwlk_pkg::pwlk_access_s cpu_acc_in,
   input wire pwlk_pkg::pwlk_access_s periph_acc_out,
   input wire logic [7:0] group_wr_en_out,
   input wire logic wr_blocked_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_lock_refuse: assert property (
      lock_wr_in && key_status_out != 2'h3 |=> lock_wr_refused_out && $stable(peripheral_group_lock_mask_out))
      else $error("lock write not refused");
   a_lock_take: assert property (
      lock_wr_in && key_status_out == 2'h3 |=> peripheral_group_lock_mask_out == $past(lock_data_in))
      else $error("lock write lost");
   a_key_first: assert property (
      key_wr_in && key_status_out == 2'h0 && key_data_in == `PWLK_KEY_FIRST |=> key_status_out == 2'h1)
      else $error("first key missed");
   a_key_second: assert property (
      key_wr_in && key_status_out == 2'h1 && key_data_in == `PWLK_KEY_SECOND |=> key_status_out == 2'h3)
      else $error("second key missed");
   a_key_rearm: assert property (
      key_wr_in && key_status_out == 2'h3 |=> key_status_out == 2'h0)
      else $error("no rearm");
   a_key_restart: assert property (
      key_wr_in && key_status_out == 2'h1 && key_data_in != `PWLK_KEY_SECOND |=> key_status_out == 2'h0)
      else $error("no restart");
   a_wr_drop: assert property (
      cpu_acc_in.valid && cpu_acc_in.write && peripheral_group_lock_mask_out[cpu_acc_in.group]
      |=> !periph_acc_out.valid && group_wr_en_out == 8'h00 && wr_blocked_out)
      else $error("locked write passed");
   a_rd_pass: assert property (
      cpu_acc_in.valid && !cpu_acc_in.write |=> periph_acc_out == $past(cpu_acc_in))
      else $error("read not forwarded");
   a_wr_lane: assert property (
      cpu_acc_in.valid && cpu_acc_in.write && !peripheral_group_lock_mask_out[cpu_acc_in.group]
      |=> periph_acc_out.valid && group_wr_en_out == (8'h01 << $past(cpu_acc_in.group)))
      else $error("open write not enabled");
   a_key_hold: assert property (
      !key_wr_in |=> $stable(key_status_out))
      else $error("key status moved");
endmodule : pwlk_top_asserts
bind pwlk_top pwlk_top_asserts chk_u (.clk_in, .rst_in, .key_wr_in, .key_data_in, .key_status_out, .lock_wr_in,
   .lock_data_in, .peripheral_group_lock_mask_out, .lock_wr_refused_out, .cpu_acc_in, .periph_acc_out,
   .group_wr_en_out, .wr_blocked_out);

//--- testbench.sv
`timescale 1ns/10ps
`include "pwlk_params.svh"
module testbench;
   logic clk_in = 1'h0, rst_in = 1'h1, kw = 1'h0, lw = 1'h0, rf, wb;
   logic [7:0] kd = 8'h00, ld = 8'h00, m = 8'h00, mask, wen;
   logic [1:0] st = 2'h0, stat;
   logic [2:0] bg, bg_exp = 3'h0;
   logic [31:0] rd, s = 32'h3f;
   logic [31:0] r [8] = '{default: 32'h0};
   pwlk_pkg::pwlk_access_s a = '0, pa;
   int fail_count = 0, checked = 0;
   pwlk_top dut_u (.clk_in, .rst_in, .key_wr_in(kw), .key_data_in(kd), .key_status_out(stat), .lock_wr_in(lw),
      .lock_data_in(ld), .peripheral_group_lock_mask_out(mask), .lock_wr_refused_out(rf), .cpu_acc_in(a),
      .periph_acc_out(pa), .group_wr_en_out(wen), .wr_blocked_out(wb), .blocked_group_out(bg));
   pwlk_periph_model mdl_u (.clk_in, .rst_in, .acc_in(pa), .wr_en_in(wen), .rd_data_out(rd));
   // free running 40 MHz clock
   initial
   begin
      forever #12.5 clk_in = ~clk_in;
   end
   function logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function pwlk_pkg::pwlk_access_s mk(input logic w, input logic [2:0] g, input logic [31:0] d);
      mk = '0;
      mk.valid = 1'h1;
      mk.write = w;
      mk.group = g;
      mk.addr = d[11:0];
      mk.wdata = d;
   endfunction : mk
   // expected key state after one key write
   function logic [1:0] key_next(input logic [1:0] cur, input logic [7:0] kv);
      if (cur == `PWLK_STATUS_LOCKED && kv == `PWLK_KEY_FIRST)
         key_next = `PWLK_STATUS_FIRST;
      else if (cur == `PWLK_STATUS_FIRST && kv == `PWLK_KEY_SECOND)
         key_next = `PWLK_STATUS_UNLOCKED;
      else
         key_next = `PWLK_STATUS_LOCKED;
   endfunction : key_next
   // what the peripheral side should see for one access
   function pwlk_pkg::pwlk_access_s fwd_exp(input pwlk_pkg::pwlk_access_s av, input logic bl);
      fwd_exp = av;
      if (bl)
      begin
         fwd_exp.valid = 1'h0;
         fwd_exp.wdata = '0;
      end
   endfunction : fwd_exp
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // one operation, then an idle edge; the bench model runs alongside
   task step(input logic k, input logic [7:0] kv, input logic l, input logic [7:0] lv,
      input pwlk_pkg::pwlk_access_s av);
      logic bl;
      @(posedge clk_in);
      kw <= k;
      kd <= kv;
      lw <= l;
      ld <= lv;
      a <= av;
      @(posedge clk_in);
      kw <= 1'h0;
      lw <= 1'h0;
      a <= '0;
      #1;
      bl = av.valid && av.write && m[av.group];
      if (bl) bg_exp = av.group;
      chk(rf, l && st != `PWLK_STATUS_UNLOCKED);
      if (l && st == `PWLK_STATUS_UNLOCKED) m = lv;
      if (k) st = key_next(st, kv);
      chk(mask, m);
      chk(stat, st);
      chk(wb, bl);
      chk(bg, bg_exp);
      chk(wen, (av.valid && av.write && !bl) ? 8'h01 << av.group : 8'h00);
      chk(pa.valid, av.valid && !bl);
      chk(pa, fwd_exp(av, bl));
      if (av.valid && !av.write) chk(pa, av);
      if (av.valid && !av.write) chk(rd, r[av.group]);
      if (av.valid && av.write && !bl) r[av.group] = av.wdata;
   endtask : step
   // every output at its reset value, and the bench model cleared to match
   task rst_chk();
      m = `PWLK_LOCK_RESET;
      st = `PWLK_STATUS_LOCKED;
      bg_exp = 3'h0;
      r = '{default: 32'h0};
      chk(stat, st);
      chk(mask, m);
      chk(rf, 1'h0);
      chk(wb, 1'h0);
      chk(bg, bg_exp);
      chk(wen, 8'h00);
      chk(pa, 49'h0);
      chk(rd, 32'h0);
   endtask : rst_chk
   // hand-written corners: refused lock, broken and complete keys, pass and drop, re-arm
   task corners();
      step(1'h0, 8'h00, 1'h1, 8'h05, '0);
      step(1'h1, 8'ha5, 1'h0, 8'h00, '0);
      step(1'h1, 8'ha5, 1'h0, 8'h00, '0);
      step(1'h1, 8'ha5, 1'h0, 8'h00, '0);
      step(1'h1, 8'hf1, 1'h0, 8'h00, '0);
      step(1'h0, 8'h00, 1'h1, 8'h05, '0);
      step(1'h0, 8'h00, 1'h0, 8'h00, mk(1'h1, 3'h2, 32'h1234));
      step(1'h0, 8'h00, 1'h0, 8'h00, mk(1'h0, 3'h2, 32'h0));
      step(1'h0, 8'h00, 1'h0, 8'h00, mk(1'h1, 3'h1, 32'h5678));
      step(1'h0, 8'h00, 1'h0, 8'h00, mk(1'h0, 3'h1, 32'h0));
      step(1'h1, 8'h00, 1'h1, 8'hff, '0);
   endtask : corners
   task end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // corners first, random traffic mixing all three ports, then a mid-run reset and the corners again
   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'h0;
      #1;
      rst_chk();
      corners();
      repeat (400)
      begin
         s = xs(s);
         if (s[1:0] == 2'h0) step(1'h1, s[2] ? (s[3] ? 8'ha5 : 8'hf1) : s[15:8], 1'h0, 8'h00, '0);
         else if (s[1:0] == 2'h1) step(s[5], 8'hf1, 1'h1, s[23:16], '0);
         else step(1'h0, 8'h00, 1'h0, 8'h00, mk(s[4], s[7:5], xs(s)));
      end
      // reset in mid-run from whatever state the random traffic left behind
      @(posedge clk_in);
      rst_in <= 1'h1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'h0;
      #1;
      rst_chk();
      corners();
      end_of_test();
   end
   // about a thousand cycles expected; five thousand means a hang
   initial
   begin
      #125000;
      fail_count++;
      end_of_test();
   end
endmodule : testbench
